/* File: inc/mmbs_pkg.sv */
package mmbs_pkg;

  // queue status codes, {hi, lo}
  localparam logic [1:0] QS_NONE = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_FLUSH = 2'h2;
  localparam logic [1:0] QS_NEXT = 2'h3;

  // mode strap level that selects maximum mode
  localparam logic MODE_MAX = 1'b0;

  // bus cycle T-states as reported by the bus unit
  typedef enum logic [2:0] {
    MMBS_TI, MMBS_T1, MMBS_T2, MMBS_T3, MMBS_TW, MMBS_T4
  } mmbs_tstate_t;

  // core-side events feeding the signalling block
  typedef struct packed {
    logic lock_prefix;
    logic instr_done;
    logic intack_cycle;
    logic intack_second;
    logic q_first;
    logic q_next;
    logic q_flush;
  } mmbs_core_t;

  // request/grant pin drive, output level and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } mmbs_pin_t;

endpackage : mmbs_pkg

/* File: rtl/mmbs_rqgt_chan.sv */
module mmbs_rqgt_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised pin level and controls
  input wire logic pin_sync,
  input wire logic enable,
  input wire logic grant_ok,
  input wire logic other_busy,
  // pin drive and status
  output mmbs_pkg::mmbs_pin_t pin,
  output logic req,
  output logic granted
);
  import mmbs_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_GRANT, ST_ECHO, ST_HOLD} mmbs_rg_state_t;

  mmbs_rg_state_t state_reg, state_next;
  logic prev_reg;
  wire pulse_in = prev_reg & ~pin_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      prev_reg <= pin_sync;
    end
  end

  // grant pulse driven one clock low; then wait for release pulse
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (enable && pulse_in) state_next = ST_REQ; // see R10
      ST_REQ: if (grant_ok && !other_busy) state_next = ST_GRANT; // see R10
      ST_GRANT: state_next = ST_ECHO;
      // own grant pulse reads back through the sync; swallow it, else it ends the hold
      ST_ECHO: if (pulse_in) state_next = ST_HOLD; // see R10
      ST_HOLD: if (pulse_in) state_next = ST_IDLE; // see R10
      default: state_next = ST_IDLE;
    endcase
  end

  assign pin.o = 1'b0;
  assign pin.oe = (state_reg == ST_GRANT);
  assign req = (state_reg == ST_REQ);
  assign granted = (state_reg == ST_GRANT) || (state_reg == ST_ECHO) || (state_reg == ST_HOLD);

endmodule : mmbs_rqgt_chan

/* File: rtl/mmbs_top.sv */
// Operation
// R1: max-mode pins only when strap low
// R2: low lock keeps other masters off
// R3: lock prefix holds lock through next instruction
// R4: lock floats high during grant sequence
// R5: acknowledge lock from first T2 to second T2
// R6: queue status shown cycle after operation
// R7: two status outputs, 00 means none
// R8: status outputs always driven
// R9: 01 first, 10 flush, 11 subsequent
// R10: request pulse, grant pulse, release pulse
// R11: line zero wins simultaneous requests
module mmbs_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode strap pin
  input wire logic mode_strap,
  // core events and bus state
  input mmbs_pkg::mmbs_core_t core,
  input mmbs_pkg::mmbs_tstate_t tstate,
  // bus lock pin, active low
  output logic bus_lock_n_o,
  output logic bus_lock_n_oe,
  // queue status pins
  output logic queue_status_hi,
  output logic queue_status_lo,
  // request/grant pins
  input wire logic request_grant_high_prio_i,
  output logic request_grant_high_prio_o,
  output logic request_grant_high_prio_oe,
  input wire logic request_grant_low_prio_i,
  output logic request_grant_low_prio_o,
  output logic request_grant_low_prio_oe,
  // local bus handed over; core must float its bus
  output logic bus_released
);
  import mmbs_pkg::*;

  // -----------------------------
  // pin synchronisers
  // -----------------------------
  logic [2:0] sync1_reg, sync2_reg;
  logic max_mode_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {mode_strap, request_grant_low_prio_i, request_grant_high_prio_i};
      sync2_reg <= sync1_reg;
    end
  end

  // strap is taken after reset release, never under the async reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      max_mode_reg <= 1'b0;
    end else begin
      max_mode_reg <= (sync2_reg[2] == MODE_MAX); // see R1
    end
  end

  // -----------------------------
  // request/grant arbitration
  // -----------------------------
  logic prefix_lock_reg, ack_lock_reg, ack_first_reg;
  wire lock_active = prefix_lock_reg | ack_lock_reg;
  wire grant_window = (tstate == MMBS_T4) || (tstate == MMBS_TI); // see R10
  wire req0, gnt0, gnt1;
  mmbs_pin_t pin0, pin1;

  mmbs_rqgt_chan u_rg0 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_sync(sync2_reg[0]),
    .enable(max_mode_reg),
    .grant_ok(grant_window && !lock_active),
    .other_busy(gnt1),
    .pin(pin0),
    .req(req0),
    .granted(gnt0)
  );

  // line one yields while line zero is requesting
  mmbs_rqgt_chan u_rg1 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_sync(sync2_reg[1]),
    .enable(max_mode_reg),
    .grant_ok(grant_window && !lock_active && !req0), // see R11
    .other_busy(gnt0),
    .pin(pin1),
    .req(),
    .granted(gnt1)
  );

  assign request_grant_high_prio_o = pin0.o;
  assign request_grant_high_prio_oe = pin0.oe & max_mode_reg;
  assign request_grant_low_prio_o = pin1.o;
  assign request_grant_low_prio_oe = pin1.oe & max_mode_reg;
  wire grant_seq = gnt0 | gnt1;
  assign bus_released = grant_seq;

  // -----------------------------
  // bus lock
  // -----------------------------
  wire in_t2 = (tstate == MMBS_T2);
  wire ack_t2_first = core.intack_cycle & !core.intack_second & in_t2;
  wire ack_t2_second = core.intack_cycle & core.intack_second & in_t2;

  // prefix lock spans the following instruction, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prefix_lock_reg <= 1'b0;
      ack_lock_reg <= 1'b0;
      ack_first_reg <= 1'b0;
    end else begin
      if (core.lock_prefix) begin
        prefix_lock_reg <= 1'b1; // see R3
      end else if (core.instr_done) begin
        prefix_lock_reg <= 1'b0; // see R3
      end
      if (ack_t2_first) begin
        ack_lock_reg <= 1'b1; // see R5
        ack_first_reg <= 1'b1;
      end else if (ack_t2_second && ack_first_reg) begin
        ack_lock_reg <= 1'b0; // see R5
        ack_first_reg <= 1'b0;
      end
    end
  end

  // float during grant; pull-up gives the weak one
  assign bus_lock_n_o = !lock_active; // see R2
  assign bus_lock_n_oe = max_mode_reg && !grant_seq; // see R4

  // -----------------------------
  // queue status
  // -----------------------------
  logic [1:0] qs_reg;
  wire [1:0] qs_next = !max_mode_reg ? QS_NONE :
                       core.q_flush ? QS_FLUSH :
                       core.q_first ? QS_FIRST :
                       core.q_next ? QS_NEXT : QS_NONE; // see R7 see R9

  // registered: code shows in the cycle after the operation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qs_reg <= QS_NONE;
    end else begin
      qs_reg <= qs_next; // see R6
    end
  end

  // always driven, no enable exists for these pins
  assign queue_status_hi = qs_reg[1]; // see R8
  assign queue_status_lo = qs_reg[0];

endmodule : mmbs_top

/* File: verification/mmbs_props.sv */
module mmbs_props (
  input wire logic clk,
  input wire logic rst_n,
  input mmbs_pkg::mmbs_core_t core,
  input mmbs_pkg::mmbs_tstate_t tstate,
  input wire logic bus_lock_n_o,
  input wire logic bus_lock_n_oe,
  input wire logic queue_status_hi,
  input wire logic queue_status_lo,
  input wire logic request_grant_high_prio_o,
  input wire logic request_grant_high_prio_oe,
  input wire logic request_grant_low_prio_oe
);
  import mmbs_pkg::*;
  wire [1:0] qs = {queue_status_hi, queue_status_lo};
  wire g0 = request_grant_high_prio_oe;
  wire g1 = request_grant_low_prio_oe;
  wire ack1 = tstate == MMBS_T2 && core.intack_cycle && !core.intack_second;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  qs_flush_a: assert property (core.q_flush |=> qs == QS_FLUSH) else $error("qs flush");
  qs_first_a: assert property (core.q_first && !core.q_flush |=> qs == QS_FIRST)
    else $error("qs first");
  qs_idle_a: assert property (core[2:0] == 3'h0 |=> qs == QS_NONE) else $error("qs idle");
  lock_on_a: assert property (core.lock_prefix && bus_lock_n_oe |=> !bus_lock_n_o)
    else $error("lock prefix");
  ack_lock_a: assert property (ack1 && bus_lock_n_oe |=> !bus_lock_n_o) else $error("ack");
  grant_float_a: assert property (g0 || g1 |-> !bus_lock_n_oe) else $error("lock float");
  grant_pulse_a: assert property (g0 |=> !g0) else $error("grant width");
  grant_one_a: assert property (!(g0 && g1)) else $error("two grants");
  grant_low_a: assert property (g0 |-> !request_grant_high_prio_o) else $error("grant level");
  lock_blocks_grant_a: assert property (!bus_lock_n_o |=> !(g0 || g1))
    else $error("grant while locked");
endmodule : mmbs_props

bind mmbs_top mmbs_props i_props (.clk, .rst_n, .core, .tstate, .bus_lock_n_o, .bus_lock_n_oe,
  .queue_status_hi, .queue_status_lo, .request_grant_high_prio_o, .request_grant_high_prio_oe,
  .request_grant_low_prio_oe);

/* File: verification/mmbs_rq_model.sv */
module mmbs_rq_model (
  input wire logic clk,
  input wire logic pin,
  input wire logic go,
  output logic drive,
  output logic granted
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    drive = 1'b0;
    granted = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        granted <= 1'b0;
        drive <= 1'b1;
        @(posedge clk);
        drive <= 1'b0;
        for (int n = 0; n < 80; n++) begin
          @(posedge clk);
          if (!pin) begin
            granted <= 1'b1;
            repeat (6) @(posedge clk);
            drive <= 1'b1;
            @(posedge clk);
            drive <= 1'b0;
            n = 80;
          end
        end
      end
    end
  end
endmodule : mmbs_rq_model

/* File: verification/mmbs_tb_top.sv */
module mmbs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mmbs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, strap = 1'b0, go0 = 1'b0, go1 = 1'b0;
  mmbs_core_t core = '0;
  mmbs_tstate_t tstate = MMBS_TI;
  logic lk, lk_oe, qh, ql, g0o, g0e, g1o, g1e, rel, d0, d1, k0, k1;
  int miscompares = 0, tests_run = 0;
  // pull-up on both request/grant lines
  wire p0 = !(d0 || (g0e && !g0o));
  wire p1 = !(d1 || (g1e && !g1o));
  mmbs_top i_dut (.clk, .rst_n, .mode_strap(strap), .core, .tstate, .bus_lock_n_o(lk),
    .bus_lock_n_oe(lk_oe), .queue_status_hi(qh), .queue_status_lo(ql),
    .request_grant_high_prio_i(p0), .request_grant_high_prio_o(g0o),
    .request_grant_high_prio_oe(g0e), .request_grant_low_prio_i(p1),
    .request_grant_low_prio_o(g1o), .request_grant_low_prio_oe(g1e), .bus_released(rel));
  mmbs_rq_model m0 (.clk, .pin(p0), .go(go0), .drive(d0), .granted(k0));
  mmbs_rq_model m1 (.clk, .pin(p1), .go(go1), .drive(d1), .granted(k1));
  initial forever #2.5 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // one event cycle, then queue code and lock level
  task ev(input logic [6:0] c, input logic [1:0] q, input logic l);
    @(posedge clk) core <= c;
    @(posedge clk) core <= '0;
    #1 chk({qh, ql, lk}, {q, l});
  endtask : ev
  task t_queue;
    ev(7'h01, QS_FLUSH, 1'b1);
    ev(7'h04, QS_FIRST, 1'b1);
    ev(7'h02, QS_NEXT, 1'b1);
    ev(7'h05, QS_FLUSH, 1'b1);
    ev(7'h00, QS_NONE, 1'b1);
    $display("queue test done");
  endtask : t_queue
  task t_lock;
    ev(7'h40, QS_NONE, 1'b0);
    ev(7'h00, QS_NONE, 1'b0);
    ev(7'h20, QS_NONE, 1'b1);
    @(posedge clk) tstate <= MMBS_T2;
    ev(7'h10, QS_NONE, 1'b0);
    ev(7'h00, QS_NONE, 1'b0);
    ev(7'h18, QS_NONE, 1'b1);
    @(posedge clk) tstate <= MMBS_TI;
    $display("lock test done");
  endtask : t_lock
  task t_grant;
    @(posedge clk) tstate <= MMBS_T4;
    go0 <= 1'b1;
    go1 <= 1'b1;
    @(posedge clk) {go0, go1} <= 2'b00;
    for (int n = 0; n < 40 && k0 !== 1'b1; n++) @(posedge clk);
    #1 chk({k0, k1, rel, lk_oe}, 4'b1010);
    for (int n = 0; n < 100 && k1 !== 1'b1; n++) @(posedge clk);
    #1 chk({k1, lk_oe, g1o}, 3'b100);
    repeat (20) @(posedge clk);
    #1 chk({rel, lk_oe}, 2'b01);
    $display("grant test done");
  endtask : t_grant
  task t_min;
    @(posedge clk) strap <= 1'b1;
    repeat (4) @(posedge clk) go0 <= 1'b1;
    @(posedge clk) go0 <= 1'b0;
    repeat (30) @(posedge clk);
    #1 chk({k0, lk_oe, g0e}, 3'b000);
    $display("mode test done");
  endtask : t_min
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_queue();
    t_lock();
    t_grant();
    t_min();
    wrap_up();
  end
  initial begin
    #5000;
    miscompares++;
    wrap_up();
  end
endmodule : mmbs_tb_top
